// file: bcr_pkg.sv
// Shared constants and types of the banked CPU register file
package bcr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int NUM_GPR = 24;
  localparam int NUM_FPR = 32;

  // ----------------------------------------------------------------
  // Bus offsets, byte addresses
  // ----------------------------------------------------------------
  localparam logic [9:0] OFF_GEN = 10'h000;
  localparam logic [9:0] SPAN_GEN = 10'h040;
  localparam logic [9:0] OFF_ALT = 10'h040;
  localparam logic [9:0] SPAN_ALT = 10'h020;
  localparam logic [9:0] OFF_SR = 10'h080;
  localparam logic [9:0] OFF_SSR = 10'h084;
  localparam logic [9:0] OFF_GBR = 10'h088;
  localparam logic [9:0] OFF_VBR = 10'h08C;
  localparam logic [9:0] OFF_SPC = 10'h090;
  localparam logic [9:0] OFF_SGR = 10'h094;
  localparam logic [9:0] OFF_DBR = 10'h098;
  localparam logic [9:0] OFF_MAC_HIGH = 10'h0A0;
  localparam logic [9:0] OFF_MAC_LOW = 10'h0A4;
  localparam logic [9:0] OFF_PR = 10'h0A8;
  localparam logic [9:0] OFF_PC = 10'h0AC;
  localparam logic [9:0] OFF_FLOAT_STATUS_CONTROL = 10'h0B0;
  localparam logic [9:0] OFF_FLOAT_TRANSFER_REGISTER = 10'h0B4;
  localparam logic [9:0] OFF_VSEL = 10'h0C0;
  localparam logic [9:0] OFF_VHI = 10'h0C4;
  localparam logic [9:0] OFF_VLO = 10'h0C8;
  localparam logic [9:0] OFF_VINFO = 10'h0CC;
  localparam logic [9:0] OFF_ASTAT = 10'h0D0;
  localparam logic [9:0] OFF_FPR = 10'h100;
  localparam logic [9:0] SPAN_FPR = 10'h080;

  // ----------------------------------------------------------------
  // Status word fields and reset values
  // ----------------------------------------------------------------
  localparam int SR_MD = 30;
  localparam int SR_RB = 29;
  localparam int SR_BL = 28;
  localparam int SR_FD = 15;
  localparam int SR_IM_LO = 4;
  localparam logic [31:0] SR_PRIV_MASK = 32'h7000_80F0;
  localparam logic [31:0] SR_USER_MASK = 32'h0000_0303;
  localparam logic [31:0] SR_EXC_SET = 32'h7000_0000;
  localparam logic [31:0] SR_RST = 32'h7000_00F0;
  localparam logic [31:0] VBR_RST = 32'h0000_0000;
  localparam logic [31:0] PC_RST = 32'h0A00_0000;
  localparam logic [31:0] FLOAT_STATUS_CONTROL_RST = 32'h0004_0001;

  // ----------------------------------------------------------------
  // Float formats
  // ----------------------------------------------------------------
  localparam int SP_SIGN = 31;
  localparam int SP_EXP_HI = 30;
  localparam int SP_EXP_W = 8;
  localparam int SP_FRAC_HI = 22;
  localparam int DP_SIGN = 63;
  localparam int DP_EXP_HI = 62;
  localparam int DP_EXP_W = 11;
  localparam int DP_FRAC_HI = 51;

  // ----------------------------------------------------------------
  // View select and access status fields
  // ----------------------------------------------------------------
  localparam int VSEL_IDX_LO = 4;
  localparam int VSEL_ELEM_LO = 8;
  localparam logic [31:0] VSEL_MASK = 32'h0000_03F7;
  localparam int AST_PRIV = 0;
  localparam int AST_UNMAP = 1;
  localparam int VINFO_SIGN = 16;
  localparam int VINFO_CLASS_LO = 12;

  typedef enum logic [1:0] {BUS_IDLE = 2'h1, BUS_ACK = 2'h2} bcr_bus_state_t;
  typedef enum logic [2:0] {VIEW_FR = 3'h0, VIEW_DR = 3'h1, VIEW_FV = 3'h2,
    VIEW_XF = 3'h3, VIEW_XD = 3'h4, VIEW_MTX = 3'h5} bcr_view_t;
  typedef enum logic [2:0] {FC_ZERO = 3'h0, FC_SUBNORM = 3'h1, FC_NORMAL = 3'h2,
    FC_INF = 3'h3, FC_NAN = 3'h4} bcr_fclass_t;

endpackage

// file: bcr_float_decode.sv
// Field decoder for single and double precision float words
`timescale 1ns/1ps
module bcr_float_decode
  import bcr_pkg::*;
(
  input wire logic [31:0] word_hi,
  input wire logic [31:0] word_lo,
  input wire logic is_double,
  output logic sign,
  output logic [10:0] exponent,
  output bcr_fclass_t fclass
);

  logic [63:0] dword;
  logic frac_zero;
  logic exp_ones;

  assign dword = {word_hi, word_lo};

  // ------------------------------------------------------------------
  // Sign, exponent and class
  // ------------------------------------------------------------------
  always_comb
  begin
    if (is_double)
    begin
      sign = dword[DP_SIGN]; // [RULE_02]
      exponent = dword[DP_EXP_HI -: DP_EXP_W]; // [RULE_02]
      frac_zero = (dword[DP_FRAC_HI:0] == '0); // [RULE_02]
      exp_ones = (exponent == 11'h7FF);
    end
    else
    begin
      sign = word_hi[SP_SIGN]; // [RULE_01]
      exponent = {3'h0, word_hi[SP_EXP_HI -: SP_EXP_W]}; // [RULE_01]
      frac_zero = (word_hi[SP_FRAC_HI:0] == '0); // [RULE_01]
      exp_ones = (exponent[7:0] == 8'hFF);
    end
    if (exponent == '0)
      fclass = frac_zero ? FC_ZERO : FC_SUBNORM;
    else if (exp_ones)
      fclass = frac_zero ? FC_INF : FC_NAN;
    else
      fclass = FC_NORMAL;
  end

endmodule

// file: bcr_regfile.sv
// Banked CPU register file with processor mode control
//
// Notes on behaviour
// [RULE_01] Single float: sign bit 31, exponent bits 30..23, fraction bits 22..0.
// [RULE_02] Double float: sign bit 63, exponent bits 62..52, fraction bits 51..0.
// [RULE_03] Two modes; user normally, privileged after exception or accepted interrupt.
// [RULE_04] Privileged with bank select 1: specifiers 0..7 hit bank 1, bank 0 alternate.
// [RULE_05] Privileged with bank select 0: specifiers 0..7 hit bank 0, bank 1 alternate.
// [RULE_06] User mode: 0..7 bank 0, 8..15 unbanked, bank 1 unreachable.
// [RULE_07] Global base and status open to both; saved and base pointers privileged only.
// [RULE_08] Mode, bank, mask, fpu-disable and level bits need privileged mode.
// [RULE_09] Mac, return link, program counter and float system registers mode-free.
// [RULE_10] Thirty-two float registers, primary and extended, on two physical banks.
// [RULE_11] Primary set as pairs or vectors; extended set as pairs or matrix.
// [RULE_12] Reset sets mode, bank, mask bits, level all ones, clears fpu-disable.
// [RULE_13] Power-on and manual reset load vector base, program counter, float status.
// [RULE_14] Mac, link, transfer, general and float registers are not cleared.
// [RULE_15] Mode comes only from the mode bit of the status word.
// [RULE_16] Mode bit 0 means user, 1 means privileged.
// [RULE_17] Mode and bank changes apply from the next access onward.
`timescale 1ns/1ps
module bcr_regfile
  import bcr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic exception_accept,
  input wire logic manual_reset_req,
  output logic privileged_mode_bit,
  output logic register_bank_select,
  output logic exception_mask_bit,
  output logic fpu_disable_bit,
  output logic [3:0] interrupt_mask_level
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [31:0] gpr [0:NUM_GPR-1];
  logic [31:0] fpr [0:NUM_FPR-1];
  logic [31:0] sr_q;
  logic [31:0] sr_d;
  logic [31:0] ssr_q;
  logic [31:0] gbr_q;
  logic [31:0] vbr_q;
  logic [31:0] spc_q;
  logic [31:0] sgr_q;
  logic [31:0] dbr_q;
  logic [31:0] mac_high_q;
  logic [31:0] mac_low_q;
  logic [31:0] pr_q;
  logic [31:0] pc_q;
  logic [31:0] float_status_control_q;
  logic [31:0] float_transfer_register_q;
  logic [31:0] vsel_q;
  logic [1:0] astat_q;
  logic [31:0] rdata_q;
  logic wait_q;
  bcr_bus_state_t state_q;

  logic md;
  logic rb;
  logic addr_ok;
  logic acc;
  logic wr_ok;
  logic [31:0] rd_value;
  logic [31:0] wdata_m;
  logic [31:0] sr_wmask;
  bcr_view_t vkind;
  logic [4:0] vphys;
  logic vdbl;
  logic vsign;
  logic [10:0] vexp;
  bcr_fclass_t vclass;

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic logic in_range(input logic [9:0] a, input logic [9:0] base,
                                    input logic [9:0] span);
    in_range = (a >= base) && (a < base + span);
  endfunction

  function automatic logic [4:0] gpr_phys(input logic [3:0] spec, input logic m,
                                          input logic b);
    if (spec[3])
      gpr_phys = {2'b10, spec[2:0]}; // [RULE_06]
    else if (m && b)
      gpr_phys = {2'b01, spec[2:0]}; // [RULE_04]
    else
      gpr_phys = {2'b00, spec[2:0]}; // [RULE_05] [RULE_06] [RULE_16]
  endfunction

  function automatic logic [4:0] alt_phys(input logic [2:0] spec, input logic b);
    if (b)
      alt_phys = {2'b00, spec}; // [RULE_04]
    else
      alt_phys = {2'b01, spec}; // [RULE_05]
  endfunction

  function automatic logic priv_only(input logic [9:0] a);
    priv_only = in_range(a, OFF_ALT, SPAN_ALT) || (a == OFF_SSR) || (a == OFF_VBR)
      || (a == OFF_SPC) || (a == OFF_SGR) || (a == OFF_DBR); // [RULE_07] [RULE_06]
  endfunction

  function automatic logic mapped(input logic [9:0] a);
    case (a)
      OFF_SR, OFF_SSR, OFF_GBR, OFF_VBR, OFF_SPC, OFF_SGR, OFF_DBR,
      OFF_MAC_HIGH, OFF_MAC_LOW, OFF_PR, OFF_PC, OFF_FLOAT_STATUS_CONTROL, OFF_FLOAT_TRANSFER_REGISTER,
      OFF_VSEL, OFF_VHI, OFF_VLO, OFF_VINFO, OFF_ASTAT: mapped = 1'b1;
      default: mapped = in_range(a, OFF_GEN, SPAN_GEN) || in_range(a, OFF_ALT, SPAN_ALT)
        || in_range(a, OFF_FPR, SPAN_FPR);
    endcase
  endfunction

  function automatic logic [4:0] view_phys(input bcr_view_t k, input logic [3:0] idx,
                                           input logic [1:0] elem);
    case (k)
      VIEW_FR: view_phys = {1'b0, idx};
      VIEW_DR: view_phys = {1'b0, idx[2:0], 1'b0}; // [RULE_11]
      VIEW_FV: view_phys = {1'b0, idx[1:0], elem}; // [RULE_11]
      VIEW_XF: view_phys = {1'b1, idx};
      VIEW_XD: view_phys = {1'b1, idx[2:0], 1'b0}; // [RULE_11]
      VIEW_MTX: view_phys = {1'b1, idx}; // [RULE_11]
      default: view_phys = {1'b0, idx};
    endcase
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    be_merge = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        be_merge[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction

  // ------------------------------------------------------------------
  // Mode and bank decode
  // ------------------------------------------------------------------
  assign md = sr_q[SR_MD]; // [RULE_15] [RULE_16] [RULE_17]
  assign rb = sr_q[SR_RB]; // [RULE_17]
  assign addr_ok = mapped(avs_address) && (md || !priv_only(avs_address)); // [RULE_07]
  assign acc = (state_q == BUS_ACK);
  assign wr_ok = acc && avs_write && addr_ok;
  assign wdata_m = be_merge(rd_value, avs_writedata, avs_byteenable);
  assign sr_wmask = md ? (SR_PRIV_MASK | SR_USER_MASK) : SR_USER_MASK; // [RULE_08]

  assign privileged_mode_bit = sr_q[SR_MD];
  assign register_bank_select = sr_q[SR_RB];
  assign exception_mask_bit = sr_q[SR_BL];
  assign fpu_disable_bit = sr_q[SR_FD];
  assign interrupt_mask_level = sr_q[SR_IM_LO +: 4];
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ------------------------------------------------------------------
  // Float views
  // ------------------------------------------------------------------
  assign vkind = bcr_view_t'(vsel_q[2:0]);
  assign vphys = view_phys(vkind, vsel_q[VSEL_IDX_LO +: 4], vsel_q[VSEL_ELEM_LO +: 2]);
  assign vdbl = (vkind == VIEW_DR) || (vkind == VIEW_XD);

  bcr_float_decode u_fdec (
    .word_hi(fpr[vphys]),
    .word_lo(fpr[vphys | 5'h01]),
    .is_double(vdbl),
    .sign(vsign),
    .exponent(vexp),
    .fclass(vclass)
  );

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  always_comb
  begin
    rd_value = '0;
    if (in_range(avs_address, OFF_GEN, SPAN_GEN))
      rd_value = gpr[gpr_phys(avs_address[5:2], md, rb)];
    else if (in_range(avs_address, OFF_ALT, SPAN_ALT))
      rd_value = gpr[alt_phys(avs_address[4:2], rb)];
    else if (in_range(avs_address, OFF_FPR, SPAN_FPR))
      rd_value = fpr[avs_address[6:2]]; // [RULE_10]
    else
    begin
      case (avs_address)
        OFF_SR: rd_value = md ? sr_q : (sr_q & SR_USER_MASK); // [RULE_08]
        OFF_SSR: rd_value = ssr_q;
        OFF_GBR: rd_value = gbr_q;
        OFF_VBR: rd_value = vbr_q;
        OFF_SPC: rd_value = spc_q;
        OFF_SGR: rd_value = sgr_q;
        OFF_DBR: rd_value = dbr_q;
        OFF_MAC_HIGH: rd_value = mac_high_q;
        OFF_MAC_LOW: rd_value = mac_low_q;
        OFF_PR: rd_value = pr_q;
        OFF_PC: rd_value = pc_q;
        OFF_FLOAT_STATUS_CONTROL: rd_value = float_status_control_q;
        OFF_FLOAT_TRANSFER_REGISTER: rd_value = float_transfer_register_q;
        OFF_VSEL: rd_value = vsel_q;
        OFF_VHI: rd_value = fpr[vphys];
        OFF_VLO: rd_value = vdbl ? fpr[vphys | 5'h01] : '0;
        OFF_VINFO: rd_value = {15'h0000, vsign, 1'b0, vclass, 1'b0, vexp};
        OFF_ASTAT: rd_value = {30'h0000_0000, astat_q};
        default: rd_value = '0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= '0;
    end
    else
    begin
      case (state_q)
        BUS_IDLE:
        begin
          if (avs_read || avs_write)
          begin
            state_q <= BUS_ACK;
            wait_q <= 1'b0;
            rdata_q <= (avs_read && addr_ok) ? rd_value : '0;
          end
        end
        BUS_ACK:
        begin
          state_q <= BUS_IDLE;
          wait_q <= 1'b1;
        end
        default:
        begin
          state_q <= BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // General registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (wr_ok && in_range(avs_address, OFF_GEN, SPAN_GEN))
      gpr[gpr_phys(avs_address[5:2], md, rb)] <= wdata_m; // [RULE_04] [RULE_05] [RULE_14]
    else if (wr_ok && in_range(avs_address, OFF_ALT, SPAN_ALT))
      gpr[alt_phys(avs_address[4:2], rb)] <= wdata_m; // [RULE_04] [RULE_05]
  end

  // ------------------------------------------------------------------
  // Float registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (wr_ok && in_range(avs_address, OFF_FPR, SPAN_FPR))
      fpr[avs_address[6:2]] <= wdata_m; // [RULE_10] [RULE_14]
    else if (wr_ok && avs_address == OFF_VHI)
      fpr[vphys] <= wdata_m; // [RULE_11]
    else if (wr_ok && avs_address == OFF_VLO && vdbl)
      fpr[vphys | 5'h01] <= wdata_m; // [RULE_11]
  end

  // ------------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------------
  always_comb
  begin
    sr_d = sr_q;
    if (wr_ok && avs_address == OFF_SR)
      sr_d = (wdata_m & sr_wmask) | (sr_q & ~sr_wmask); // [RULE_08]
    if (exception_accept)
      sr_d = sr_d | SR_EXC_SET; // [RULE_03]
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      sr_q <= SR_RST; // [RULE_12]
    else if (manual_reset_req)
      sr_q <= SR_RST; // [RULE_12]
    else
      sr_q <= sr_d; // [RULE_17]
  end

  // ------------------------------------------------------------------
  // Registers with defined reset values
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vbr_q <= VBR_RST; // [RULE_13]
      pc_q <= PC_RST; // [RULE_13]
      float_status_control_q <= FLOAT_STATUS_CONTROL_RST; // [RULE_13]
    end
    else if (manual_reset_req)
    begin
      vbr_q <= VBR_RST; // [RULE_13]
      pc_q <= PC_RST; // [RULE_13]
      float_status_control_q <= FLOAT_STATUS_CONTROL_RST; // [RULE_13]
    end
    else if (wr_ok)
    begin
      case (avs_address)
        OFF_VBR: vbr_q <= wdata_m;
        OFF_PC: pc_q <= wdata_m; // [RULE_09]
        OFF_FLOAT_STATUS_CONTROL: float_status_control_q <= wdata_m; // [RULE_09]
        default: vbr_q <= vbr_q;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Registers left undefined after reset
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (wr_ok)
    begin
      case (avs_address)
        OFF_SSR: ssr_q <= wdata_m;
        OFF_GBR: gbr_q <= wdata_m;
        OFF_SPC: spc_q <= wdata_m;
        OFF_SGR: sgr_q <= wdata_m;
        OFF_DBR: dbr_q <= wdata_m;
        OFF_MAC_HIGH: mac_high_q <= wdata_m; // [RULE_09] [RULE_14]
        OFF_MAC_LOW: mac_low_q <= wdata_m; // [RULE_09] [RULE_14]
        OFF_PR: pr_q <= wdata_m; // [RULE_09] [RULE_14]
        OFF_FLOAT_TRANSFER_REGISTER: float_transfer_register_q <= wdata_m; // [RULE_09] [RULE_14]
        default: ssr_q <= ssr_q;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // View select and access status
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      vsel_q <= '0;
    else if (wr_ok && avs_address == OFF_VSEL)
      vsel_q <= wdata_m & VSEL_MASK;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      astat_q <= '0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (acc && mapped(avs_address) && !addr_ok && i == AST_PRIV)
          astat_q[i] <= 1'b1; // [RULE_07] [RULE_06]
        else if (acc && !mapped(avs_address) && i == AST_UNMAP)
          astat_q[i] <= 1'b1;
        else if (wr_ok && avs_address == OFF_ASTAT && avs_byteenable[0]
                 && avs_writedata[i])
          astat_q[i] <= 1'b0;
      end
    end
  end

endmodule

// file: bcr_regfile_props.sv
// Port checks of the banked register file
`timescale 1ns/1ps
module bcr_regfile_props
  import bcr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic exception_accept,
  input wire logic manual_reset_req,
  input wire logic privileged_mode_bit,
  input wire logic register_bank_select,
  input wire logic exception_mask_bit,
  input wire logic fpu_disable_bit,
  input wire logic [3:0] interrupt_mask_level
);
  // ------
  // Checks
  // ------
  logic take;
  logic rd_sr;
  logic priv_addr;
  logic pulse;
  logic [7:0] sbits;
  assign take = (avs_read || avs_write) && avs_waitrequest;
  assign rd_sr = take && avs_read && avs_address == OFF_SR;
  assign priv_addr = avs_address[9:5] == 5'h02
    || avs_address inside {OFF_SSR, OFF_VBR, OFF_SPC, OFF_SGR, OFF_DBR};
  assign pulse = exception_accept || manual_reset_req;
  assign sbits = {privileged_mode_bit, register_bank_select, exception_mask_bit,
    fpu_disable_bit, interrupt_mask_level};
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  AST_ANSWER_NEXT:
    assert property (take |=> !avs_waitrequest) else $error("request not answered");
  AST_ONE_LOW:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
  AST_EXC_ENTRY:
    assert property (exception_accept |=> sbits[7:5] == 3'b111) else $error("no entry");
  AST_MRST_LOAD:
    assert property (manual_reset_req |=> sbits == 8'hEF) else $error("manual reset");
  AST_RST_STATUS:
    assert property ($rose(resetn) |-> sbits == 8'hEF) else $error("reset status");
  AST_USER_LOCK:
    assert property (!privileged_mode_bit && !pulse |=> !sbits[7] && $stable(sbits[6:0]))
    else $error("user changed locked bits");
  AST_HOLD:
    assert property (!avs_write && !pulse |=> $stable(sbits)) else $error("bits moved");
  AST_USER_DENY:
    assert property (take && avs_read && !privileged_mode_bit && priv_addr
      |=> avs_readdata == 32'h0000_0000) else $error("user read not refused");
  AST_SR_RESV:
    assert property (rd_sr |=> (avs_readdata & ~(SR_PRIV_MASK | SR_USER_MASK)) == 32'h0)
    else $error("reserved status bits set");
  AST_SR_MIRROR:
    assert property (rd_sr |=> avs_readdata[SR_MD] == $past(privileged_mode_bit)
      && avs_readdata[SR_RB] == $past(register_bank_select)) else $error("mode mirror");
  cover property (exception_accept);
  cover property (manual_reset_req);
  cover property (take && !privileged_mode_bit && priv_addr);
endmodule

bind bcr_regfile bcr_regfile_props chk_u (
  .ref_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .exception_accept,
  .manual_reset_req, .privileged_mode_bit, .register_bank_select,
  .exception_mask_bit, .fpu_disable_bit, .interrupt_mask_level
);

// file: bcr_pipe_model.sv
// Pipeline model raising exception and manual reset pulses
`timescale 1ns/1ps
module bcr_pipe_model (
  input wire logic ref_clk,
  output logic exception_accept,
  output logic manual_reset_req
);
  // ------
  // Pulses
  // ------
  initial
  begin
    exception_accept = 1'b0;
    manual_reset_req = 1'b0;
  end
  // One-cycle exception entry after dly idle cycles
  task automatic raise_exc(input int dly);
    repeat (dly) @(posedge ref_clk);
    exception_accept <= 1'b1;
    @(posedge ref_clk);
    exception_accept <= 1'b0;
    @(posedge ref_clk);
  endtask
  // One-cycle manual reset after dly idle cycles
  task automatic raise_mrst(input int dly);
    repeat (dly) @(posedge ref_clk);
    manual_reset_req <= 1'b1;
    @(posedge ref_clk);
    manual_reset_req <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule

// file: test_banked_cpu_register_file.sv
// Self-checking bench of the banked register file
`timescale 1ns/1ps
`define CHK(g, e) check(g, e)
module test_banked_cpu_register_file
  import bcr_pkg::*;
;
  typedef struct packed {logic [9:0] a; logic [31:0] d; logic [31:0] e;} bcr_row_t;
  localparam bcr_row_t ROWS [13] = '{
    '{OFF_GBR, 32'h1234_5678, 32'h1234_5678}, '{OFF_SSR, 32'h0000_0111, 32'h0000_0111},
    '{OFF_VBR, 32'h0000_0222, 32'h0000_0222}, '{OFF_SPC, 32'h0000_0333, 32'h0000_0333},
    '{OFF_SGR, 32'h0000_0444, 32'h0000_0444}, '{OFF_DBR, 32'h0000_0555, 32'h0000_0555},
    '{OFF_MAC_HIGH, 32'h0000_0ACE, 32'h0000_0ACE}, '{OFF_MAC_LOW, 32'h0000_0666, 32'h0000_0666},
    '{OFF_PR, 32'h0000_0777, 32'h0000_0777}, '{OFF_FLOAT_TRANSFER_REGISTER, 32'h0000_0888, 32'h0000_0888},
    '{10'h020, 32'h0000_0999, 32'h0000_0999}, '{OFF_SR, 32'hFFFF_FFFF, 32'h7000_83F3},
    '{10'h3FC, 32'hFFFF_FFFF, 32'h0000_0000}};
  // View select, expected high word, expected decode
  localparam bcr_row_t VIEWS [6] = '{
    '{10'h000, 32'hC000_0000, 32'h0001_2080}, '{10'h001, 32'hC000_0000, 32'h0001_2400},
    '{10'h212, 32'h0000_0606, 32'h0000_1000}, '{10'h003, 32'h0000_0F00, 32'h0000_1000},
    '{10'h004, 32'h0000_0F00, 32'h0000_1000}, '{10'h005, 32'h0000_0F00, 32'h0000_1000}};
  logic ref_clk;
  logic resetn;
  logic [9:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic exception_accept;
  logic manual_reset_req;
  logic privileged_mode_bit;
  logic register_bank_select;
  logic exception_mask_bit;
  logic fpu_disable_bit;
  logic [3:0] interrupt_mask_level;
  logic [31:0] q;
  int err_count;
  int num_checks;

  bcr_regfile dut_u (
    .ref_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .exception_accept,
    .manual_reset_req, .privileged_mode_bit, .register_bank_select,
    .exception_mask_bit, .fpu_disable_bit, .interrupt_mask_level
  );
  bcr_pipe_model pm_u (.ref_clk, .exception_accept, .manual_reset_req);

  always #5 ref_clk = ~ref_clk;

  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] stat();
    return {24'h0, privileged_mode_bit, register_bank_select, exception_mask_bit,
      fpu_disable_bit, interrupt_mask_level};
  endfunction
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One bus transfer; read data lands in q
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    if (n >= 20)
    begin
      err_count++;
      end_of_test();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------
  // Sequence
  // ----------
  initial
  begin
    #100us;
    err_count++;
    end_of_test();
  end
  initial
  begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    err_count = 0;
    num_checks = 0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    `CHK(stat(), 32'h0000_00EF);
    xfer(1'b0, OFF_SR, '0);
    `CHK(q, SR_RST);
    xfer(1'b0, OFF_VBR, '0);
    `CHK(q, VBR_RST);
    xfer(1'b0, OFF_PC, '0);
    `CHK(q, PC_RST);
    xfer(1'b0, OFF_FLOAT_STATUS_CONTROL, '0);
    `CHK(q, FLOAT_STATUS_CONTROL_RST);
    foreach (ROWS[i])
    begin
      xfer(1'b1, ROWS[i].a, ROWS[i].d);
      xfer(1'b0, ROWS[i].a, '0);
      `CHK(q, ROWS[i].e);
    end
    xfer(1'b1, 10'h000, 32'h0000_00A1);
    xfer(1'b1, OFF_ALT, 32'h0000_00B0);
    xfer(1'b1, OFF_SR, 32'h5000_00F0);
    xfer(1'b0, 10'h000, '0);
    `CHK(q, 32'h0000_00B0);
    xfer(1'b0, OFF_ALT, '0);
    `CHK(q, 32'h0000_00A1);
    xfer(1'b1, OFF_FPR, 32'hC000_0000);
    xfer(1'b1, OFF_FPR + 10'h004, 32'h0000_0000);
    xfer(1'b1, OFF_FPR + 10'h018, 32'h0000_0606);
    xfer(1'b1, OFF_FPR + 10'h040, 32'h0000_0F00);
    xfer(1'b1, OFF_FPR + 10'h044, 32'h0000_0000);
    xfer(1'b0, OFF_FPR + 10'h040, '0);
    `CHK(q, 32'h0000_0F00);
    foreach (VIEWS[i])
    begin
      xfer(1'b1, OFF_VSEL, {22'h0, VIEWS[i].a});
      xfer(1'b0, OFF_VHI, '0);
      `CHK(q, VIEWS[i].d);
      xfer(1'b0, OFF_VINFO, '0);
      `CHK(q, VIEWS[i].e);
    end
    xfer(1'b1, OFF_SR, 32'h0000_0000);
    `CHK(stat(), 32'h0000_0000);
    xfer(1'b0, 10'h000, '0);
    `CHK(q, 32'h0000_00B0);
    xfer(1'b0, 10'h020, '0);
    `CHK(q, 32'h0000_0999);
    xfer(1'b0, OFF_ALT, '0);
    `CHK(q, 32'h0000_0000);
    xfer(1'b0, OFF_VBR, '0);
    `CHK(q, 32'h0000_0000);
    xfer(1'b0, OFF_GBR, '0);
    `CHK(q, 32'h1234_5678);
    xfer(1'b0, OFF_MAC_HIGH, '0);
    `CHK(q, 32'h0000_0ACE);
    avs_byteenable <= 4'h1;
    xfer(1'b1, OFF_GBR, 32'hFFFF_FFAA);
    avs_byteenable <= 4'hF;
    xfer(1'b0, OFF_GBR, '0);
    `CHK(q, 32'h1234_56AA);
    xfer(1'b1, OFF_SR, 32'hFFFF_FFFF);
    xfer(1'b0, OFF_SR, '0);
    `CHK(q, 32'h0000_0303);
    xfer(1'b0, OFF_ASTAT, '0);
    `CHK(q, 32'h0000_0003);
    xfer(1'b1, OFF_ASTAT, 32'h0000_0003);
    xfer(1'b0, OFF_ASTAT, '0);
    `CHK(q, 32'h0000_0000);
    pm_u.raise_exc(2);
    `CHK(stat(), 32'h0000_00E0);
    xfer(1'b0, 10'h000, '0);
    `CHK(q, 32'h0000_00A1);
    xfer(1'b1, OFF_VBR, 32'h0000_0400);
    xfer(1'b1, OFF_PC, 32'h0000_1000);
    pm_u.raise_mrst(0);
    xfer(1'b0, OFF_VBR, '0);
    `CHK(q, VBR_RST);
    xfer(1'b0, OFF_PC, '0);
    `CHK(q, PC_RST);
    xfer(1'b0, OFF_SR, '0);
    `CHK(q, SR_RST);
    xfer(1'b1, OFF_SR, 32'h0000_0000);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK(stat(), 32'h0000_00EF);
    resetn <= 1'b1;
    @(posedge ref_clk);
    xfer(1'b0, OFF_PC, '0);
    `CHK(q, PC_RST);
    end_of_test();
  end
endmodule
